/* File: src/e1rxs_map.svh */
// Register indices, field positions, reset values and timing counts for
// the receive alarm, status and counter-update block.
// Assumes a 100 MHz pclk and an E1 or T1 receive line clock on rx_clk.
`ifndef E1RXS_MAP_SVH
`define E1RXS_MAP_SVH

// Register indices; byte address is four times the index
`define E1RXS_IDX_RTS7 10'h062
`define E1RXS_IDX_ERROR_COUNTER_CONFIG 10'h086
`define E1RXS_IDX_RX_LATCHED_ALARM_STATUS_C 10'h092
`define E1RXS_IDX_RX_LATCHED_EVENT_STATUS_D 10'h093
`define E1RXS_IDX_RX_IRQ_MASK_C 10'h0a2
`define E1RXS_IDX_RX_IRQ_MASK_D 10'h0a3
`define E1RXS_IDX_SCE1 10'h0c0
`define E1RXS_IDX_CTRL 10'h0c1

// Reset values
`define E1RXS_RST_REG 8'h00

// Writable or settable bits of each register
`define E1RXS_MASK_C 8'hbb
`define E1RXS_MASK_D 8'h0f
`define E1RXS_MASK_ERROR_COUNTER_CONFIG 8'hf9
`define E1RXS_MASK_CTRL 8'h07

// Error counter configuration fields
`define E1RXS_EC_SHSEC 7
`define E1RXS_EC_MANUAL_SOURCE_SELECT 6
`define E1RXS_EC_MANUAL_COUNTER_UPDATE 5
`define E1RXS_EC_UPDATE_INTERVAL_SELECT 4
`define E1RXS_EC_ACCUMULATION_MODE_SELECT 3
`define E1RXS_EC_LCV 0

// Control register fields
`define E1RXS_CT_CRCEN 0
`define E1RXS_CT_T1 1
`define E1RXS_CT_CASEN 2

// Positions in the synchronised input vector
`define E1RXS_IN_RXCLK 0
`define E1RXS_IN_LINK 1
`define E1RXS_IN_BIT6 2
`define E1RXS_IN_CRCSA 3
`define E1RXS_IN_SIGNALING_MF_SEARCH_ACTIVE 4
`define E1RXS_IN_FRAME_ALIGN_SEARCH_ACTIVE 5
`define E1RXS_IN_CRCEXP 6
`define E1RXS_IN_CASMF 7
`define E1RXS_IN_SHSEC 8
`define E1RXS_IN_GLOBAL_COUNTER_LATCH 9
`define E1RXS_IN_SIG 10
`define E1RXS_IN_W 18

// Timing
`define E1RXS_PCLK_NS 10
`define E1RXS_CHAN_TIME_NS 3906
`define E1RXS_LOST_CYC (`E1RXS_CHAN_TIME_NS / `E1RXS_PCLK_NS)
`define E1RXS_E1_BIT_HZ 2048000
`define E1RXS_T1_BIT_HZ 1544000
`define E1RXS_E1_FRAME_BITS 256
`define E1RXS_T1_FRAME_BITS 193
`define E1RXS_E1_SHORT_FRAMES 500
`define E1RXS_T1_SHORT_FRAMES 336
`define E1RXS_MF_TIME_US 2000
`define E1RXS_MF_E1_BITS ((`E1RXS_E1_BIT_HZ / 1000) * `E1RXS_MF_TIME_US / 1000)
`define E1RXS_MF_T1_BITS ((`E1RXS_T1_BIT_HZ / 1000) * `E1RXS_MF_TIME_US / 1000)

`endif

/* File: src/e1rxs_pkg.sv */
// Types for the receive alarm, status and counter-update block.
// Assumes e1rxs_map.svh supplies the widths of the input vector.
`include "e1rxs_map.svh"

package e1rxs_pkg;

  typedef logic [`E1RXS_IN_W-1:0] e1rxs_in_type;

  // Whole state of the block, registered in one process
  typedef struct packed {
    e1rxs_in_type s1;
    e1rxs_in_type s2;
    e1rxs_in_type s3;
    logic [8:0] lost_cnt;
    logic clock_lost;
    logic [1:0] dma_cnt;
    logic dma;
    logic [5:0] crc_cnt;
    logic [20:0] sec_cnt;
    logic [20:0] tmr_cnt;
    logic [12:0] mf_cnt;
    logic [7:0] rx_latched_alarm_status_c;
    logic [7:0] rx_latched_event_status_d;
    logic [7:0] rx_irq_mask_c;
    logic [7:0] rx_irq_mask_d;
    logic [7:0] error_counter_config;
    logic [7:0] sce1;
    logic [7:0] ctrl;
    logic counter_latch;
    logic irq;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } e1rxs_state_type;

endpackage : e1rxs_pkg

/* File: src/e1rxs_status.sv */
// Receive alarm latches, sync status, timing events and error-counter
// update control for one framer, with an APB register slave.
// Assumes all line-side inputs are asynchronous to pclk; toggles mark events.
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
`include "e1rxs_map.svh"

// Functional notes
// - Alarm latches hold and can interrupt
// - Clock-lost falling edge sets bit 7
// - Clock-lost rising edge sets bit 3
// - Link id rise bit 1, fall bit 5
// - Distant alarm after two multiframes; edges latch
// - Mask bit 1 passes, 0 blocks
// - Sync counter counts search timeouts
// - Sync counter clears on sync or disable
// - Six-bit rolling counter, bit 1 hidden
// - Three search-active real-time bits
// - Enabled channel signaling change sets bit 3
// - One-second event from line clock
// - Timer event at update interval
// - Multiframe event every 2 ms, or at each boundary with signaling on
// - Shared second select in timed mode
// - Manual source: local or global latch
// - Manual bit rise latches counters in the same cycle
// - Interval one second or short interval
// - Accumulation mode timed or manual
// - Excess zeros counted when bit 0 set
module e1rxs_status #(
  parameter logic [20:0] SEC_E1_BITS = 21'(`E1RXS_E1_BIT_HZ),
  parameter logic [20:0] SEC_T1_BITS = 21'(`E1RXS_T1_BIT_HZ),
  parameter logic [20:0] SHORT_E1_BITS = 21'(`E1RXS_E1_SHORT_FRAMES * `E1RXS_E1_FRAME_BITS),
  parameter logic [20:0] SHORT_T1_BITS = 21'(`E1RXS_T1_SHORT_FRAMES * `E1RXS_T1_FRAME_BITS)
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_clk,
  input wire logic link_id_seen,
  input wire logic ts16_f0_bit6,
  input wire logic crc_mf_search_active,
  input wire logic signaling_mf_search_active,
  input wire logic frame_align_search_active,
  input wire logic crc_search_expired_tgl,
  input wire logic cas_mf_boundary_tgl,
  input wire logic shared_second_tgl,
  input wire logic global_counter_latch,
  input wire logic [7:0] sig_change_tgl,
  output logic counter_latch,
  output logic count_excess_zeros,
  output logic irq
);
  import e1rxs_pkg::*;

  localparam logic [8:0] LOST_CYC = 9'(`E1RXS_LOST_CYC);
  localparam logic [20:0] MF_E1 = 21'(`E1RXS_MF_E1_BITS);
  localparam logic [20:0] MF_T1 = 21'(`E1RXS_MF_T1_BITS);

  e1rxs_state_type q;
  e1rxs_state_type d;
  e1rxs_in_type raw;
  e1rxs_in_type rise;
  e1rxs_in_type fall;
  e1rxs_in_type tog;

  // Wrapping counter step: returns zero at the last count of a period
  function automatic logic [20:0] wrap_inc(input logic [20:0] c, input logic [20:0] len);
    wrap_inc = (c >= len - 21'h000001) ? 21'h000000 : c + 21'h000001;
  endfunction : wrap_inc

  // Last count of a period reached
  function automatic logic at_end(input logic [20:0] c, input logic [20:0] len);
    at_end = (c >= len - 21'h000001);
  endfunction : at_end

  // Latched status: set wins over a write-one clear
  function automatic logic [7:0] w1c(input logic [7:0] cur, input logic [7:0] set,
                                     input logic [7:0] clr, input logic [7:0] keep);
    w1c = ((cur & ~clr) | set) & keep;
  endfunction : w1c

  // Line-side inputs collected into one vector
  assign raw = {sig_change_tgl, global_counter_latch, shared_second_tgl, cas_mf_boundary_tgl,
                crc_search_expired_tgl, frame_align_search_active,
                signaling_mf_search_active, crc_mf_search_active, ts16_f0_bit6,
                link_id_seen, rx_clk};

  // Edges seen only past the second synchroniser stage
  assign rise = q.s2 & ~q.s3;
  assign fall = ~q.s2 & q.s3;
  assign tog = q.s2 ^ q.s3;

  // Outputs straight from state flops
  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign counter_latch = q.counter_latch;
  assign count_excess_zeros = q.error_counter_config[`E1RXS_EC_LCV];
  assign irq = q.irq;

  // Next-state logic for the whole block
  always_comb begin
    logic rx_edge;
    logic t1;
    logic wr;
    logic [9:0] idx;
    logic [7:0] set_c;
    logic [7:0] set_d;
    logic [7:0] clr_c;
    logic [7:0] clr_d;
    logic [7:0] rd;
    logic hit;
    logic sec_tick;
    logic tmr_tick;
    logic mf_evt;
    logic sig_chg;
    logic manual_counter_update_rise;
    logic [20:0] short_len;
    logic [20:0] sec_len;
    d = q;
    rx_edge = rise[`E1RXS_IN_RXCLK];
    t1 = q.ctrl[`E1RXS_CT_T1];
    wr = psel & penable & q.pready & pwrite;
    idx = paddr[11:2];
    clr_c = 8'h00;
    clr_d = 8'h00;
    rd = 8'h00;
    hit = 1'b1;
    tmr_tick = 1'b0;
    mf_evt = 1'b0;
    d.s1 = raw;
    d.s2 = q.s1;
    d.s3 = q.s2;

    if (tog[`E1RXS_IN_RXCLK]) begin
      d.lost_cnt = 9'h000;
    end else if (q.lost_cnt != LOST_CYC) begin
      d.lost_cnt = q.lost_cnt + 9'h001;
    end
    d.clock_lost = (d.lost_cnt == LOST_CYC);

    // two consecutive multiframes with bit 6 set
    if (tog[`E1RXS_IN_CASMF]) begin
      if (q.s2[`E1RXS_IN_BIT6]) begin
        d.dma_cnt = (q.dma_cnt == 2'h2) ? 2'h2 : q.dma_cnt + 2'h1;
      end else begin
        d.dma_cnt = 2'h0;
      end
    end
    d.dma = (d.dma_cnt == 2'h2);

    // clear on sync or mode disable
    if (!q.ctrl[`E1RXS_CT_CRCEN] || fall[`E1RXS_IN_CRCSA]) begin
      d.crc_cnt = 6'h00;
    end else if (tog[`E1RXS_IN_CRCEXP]) begin
      d.crc_cnt = q.crc_cnt + 6'h01;
    end

    // one second counted in line bits
    sec_len = t1 ? SEC_T1_BITS : SEC_E1_BITS;
    sec_tick = rx_edge & at_end(q.sec_cnt, sec_len);
    if (rx_edge) begin
      d.sec_cnt = wrap_inc(q.sec_cnt, sec_len);
    end

    short_len = t1 ? SHORT_T1_BITS : SHORT_E1_BITS;
    if (q.error_counter_config[`E1RXS_EC_UPDATE_INTERVAL_SELECT]) begin
      tmr_tick = rx_edge & at_end(q.tmr_cnt, short_len);
      if (rx_edge) begin
        d.tmr_cnt = wrap_inc(q.tmr_cnt, short_len);
      end
    end else begin
      tmr_tick = sec_tick;
      d.tmr_cnt = 21'h000000;
    end

    // free 2 ms count, replaced by boundaries with signaling on
    if (rx_edge) begin
      d.mf_cnt = 13'(wrap_inc(21'(q.mf_cnt), t1 ? MF_T1 : MF_E1));
    end
    if (q.ctrl[`E1RXS_CT_CASEN]) begin
      mf_evt = tog[`E1RXS_IN_CASMF];
    end else begin
      mf_evt = rx_edge & at_end(21'(q.mf_cnt), t1 ? MF_T1 : MF_E1);
    end

    // only enabled channels raise the event
    sig_chg = |(tog[`E1RXS_IN_SIG +: 8] & q.sce1);

    set_c = {~d.clock_lost & q.clock_lost, 1'b0, fall[`E1RXS_IN_LINK], ~d.dma & q.dma,
             d.clock_lost & ~q.clock_lost, 1'b0, rise[`E1RXS_IN_LINK], d.dma & ~q.dma};
    set_d = {4'h0, sig_chg, sec_tick, tmr_tick, mf_evt};

    // Register read mux and unmapped decode
    unique case (idx)
      `E1RXS_IDX_RTS7: rd = {q.crc_cnt[5:2], q.crc_cnt[0], q.s2[`E1RXS_IN_CRCSA],
                            q.s2[`E1RXS_IN_SIGNALING_MF_SEARCH_ACTIVE], q.s2[`E1RXS_IN_FRAME_ALIGN_SEARCH_ACTIVE]};
      `E1RXS_IDX_ERROR_COUNTER_CONFIG: rd = q.error_counter_config;
      `E1RXS_IDX_RX_LATCHED_ALARM_STATUS_C: rd = q.rx_latched_alarm_status_c;
      `E1RXS_IDX_RX_LATCHED_EVENT_STATUS_D: rd = q.rx_latched_event_status_d;
      `E1RXS_IDX_RX_IRQ_MASK_C: rd = q.rx_irq_mask_c;
      `E1RXS_IDX_RX_IRQ_MASK_D: rd = q.rx_irq_mask_d;
      `E1RXS_IDX_SCE1: rd = q.sce1;
      `E1RXS_IDX_CTRL: rd = q.ctrl;
      default: hit = 1'b0;
    endcase

    // Writes land only at the completing edge
    if (wr) begin
      unique case (idx)
        `E1RXS_IDX_ERROR_COUNTER_CONFIG: d.error_counter_config = pwdata[7:0] & `E1RXS_MASK_ERROR_COUNTER_CONFIG;
        `E1RXS_IDX_RX_LATCHED_ALARM_STATUS_C: clr_c = pwdata[7:0];
        `E1RXS_IDX_RX_LATCHED_EVENT_STATUS_D: clr_d = pwdata[7:0];
        `E1RXS_IDX_RX_IRQ_MASK_C: d.rx_irq_mask_c = pwdata[7:0] & `E1RXS_MASK_C;
        `E1RXS_IDX_RX_IRQ_MASK_D: d.rx_irq_mask_d = pwdata[7:0] & `E1RXS_MASK_D;
        `E1RXS_IDX_SCE1: d.sce1 = pwdata[7:0];
        `E1RXS_IDX_CTRL: d.ctrl = pwdata[7:0] & `E1RXS_MASK_CTRL;
        default: d.ctrl = q.ctrl;
      endcase
    end

    d.rx_latched_alarm_status_c = w1c(q.rx_latched_alarm_status_c, set_c, clr_c, `E1RXS_MASK_C);
    d.rx_latched_event_status_d = w1c(q.rx_latched_event_status_d, set_d, clr_d, `E1RXS_MASK_D);

    d.irq = |(d.rx_latched_alarm_status_c & d.rx_irq_mask_c) | |(d.rx_latched_event_status_d & d.rx_irq_mask_d);

    // local manual bit going from 0 to 1
    manual_counter_update_rise = d.error_counter_config[`E1RXS_EC_MANUAL_COUNTER_UPDATE] & ~q.error_counter_config[`E1RXS_EC_MANUAL_COUNTER_UPDATE];

    if (q.error_counter_config[`E1RXS_EC_ACCUMULATION_MODE_SELECT] | d.error_counter_config[`E1RXS_EC_ACCUMULATION_MODE_SELECT]) begin
      // local bit or shared global latch
      d.counter_latch = d.error_counter_config[`E1RXS_EC_MANUAL_SOURCE_SELECT] ? rise[`E1RXS_IN_GLOBAL_COUNTER_LATCH] : manual_counter_update_rise;
    end else begin
      d.counter_latch = q.error_counter_config[`E1RXS_EC_SHSEC] ? tog[`E1RXS_IN_SHSEC] : tmr_tick;
    end

    // APB: one wait state, data ready with pready
    if (psel & penable & ~q.pready) begin
      d.pready = 1'b1;
      d.pslverr = ~hit;
      d.prdata = {24'h000000, rd};
    end else begin
      d.pready = 1'b0;
      d.pslverr = 1'b0;
    end
  end

  // One register for all state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_lost_detect;
    $rose(q.clock_lost) |=> q.rx_latched_alarm_status_c[3];
  endproperty
  a_lost_detect: assert property (p_lost_detect)
    else $error("clock lost detect flag not latched");

  property p_lost_clear;
    $fell(q.clock_lost) |=> q.rx_latched_alarm_status_c[7];
  endproperty
  a_lost_clear: assert property (p_lost_clear)
    else $error("clock lost cleared flag not latched");

  property p_link_edges;
    (rise[`E1RXS_IN_LINK] |=> q.rx_latched_alarm_status_c[1]) and (fall[`E1RXS_IN_LINK] |=> q.rx_latched_alarm_status_c[5]);
  endproperty
  a_link_edges: assert property (p_link_edges)
    else $error("link id edge flag not latched");

  property p_dma_rise;
    $rose(q.dma) |=> q.rx_latched_alarm_status_c[0];
  endproperty
  a_dma_rise: assert property (p_dma_rise)
    else $error("distant alarm detect flag not latched");

  property p_lost_timeout;
    tog[`E1RXS_IN_RXCLK] |=> !q.clock_lost;
  endproperty
  a_lost_timeout: assert property (p_lost_timeout)
    else $error("clock lost while line clock toggles");

  property p_irq_mask;
    (|(q.rx_latched_alarm_status_c & q.rx_irq_mask_c) || |(q.rx_latched_event_status_d & q.rx_irq_mask_d)) |-> q.irq;
  endproperty
  a_irq_mask: assert property (p_irq_mask)
    else $error("unmasked flag gives no interrupt");

  property p_irq_none;
    (q.rx_irq_mask_c == 8'h00 && q.rx_irq_mask_d == 8'h00) |-> !q.irq;
  endproperty
  a_irq_none: assert property (p_irq_none)
    else $error("interrupt with all masks clear");

  property p_crc_clear;
    !q.ctrl[`E1RXS_CT_CRCEN] |=> q.crc_cnt == 6'h00;
  endproperty
  a_crc_clear: assert property (p_crc_clear)
    else $error("sync counter not cleared while disabled");

  property p_sec_event;
    $rose(q.counter_latch) && !q.error_counter_config[`E1RXS_EC_ACCUMULATION_MODE_SELECT] && !q.error_counter_config[`E1RXS_EC_SHSEC]
      && !q.error_counter_config[`E1RXS_EC_UPDATE_INTERVAL_SELECT] |-> q.rx_latched_event_status_d[2] && q.rx_latched_event_status_d[1];
  endproperty
  a_sec_event: assert property (p_sec_event)
    else $error("one second event missing at timed update");

  property p_manual;
    $rose(q.error_counter_config[`E1RXS_EC_MANUAL_COUNTER_UPDATE]) && q.error_counter_config[`E1RXS_EC_ACCUMULATION_MODE_SELECT]
      && !q.error_counter_config[`E1RXS_EC_MANUAL_SOURCE_SELECT] |-> q.counter_latch;
  endproperty
  a_manual: assert property (p_manual)
    else $error("manual update gave no counter latch");

  property p_apb_wait;
    psel && penable && !q.pready |=> q.pready ##1 !q.pready;
  endproperty
  a_apb_wait: assert property (p_apb_wait)
    else $error("access not answered after one wait state");

endmodule : e1rxs_status

/* File: testbench/e1rxs_line_model.sv */
// Model of the receive line side feeding the status block.
// Assumes the bench drives rx_run and calls put and flip at pclk edges.
`timescale 1ns/1ps
module e1rxs_line_model (
  input wire logic pclk,
  input wire logic rx_run,
  output logic rx_clk,
  output logic [17:0] lv
);
  // Line clock, 160 ns period, stands still while rx_run is low
  initial begin
    rx_clk = 1'b0;
    lv = '0;
    #3;
    forever begin
      #80;
      if (rx_run) rx_clk = ~rx_clk;
    end
  end

  // Level change, held long enough to cross the sync flops
  task automatic put(input int i, input logic v);
    @(posedge pclk);
    lv[i] <= v;
    repeat (6) @(posedge pclk);
  endtask : put

  // One event on a toggle line
  task automatic flip(input int i);
    put(i, ~lv[i]);
  endtask : flip
endmodule : e1rxs_line_model

/* File: testbench/tb.sv */
// Self-checking bench for the receive status block over APB.
// Assumes the line model file and shortened one-second and short counts.
`timescale 1ns/1ps
`include "e1rxs_map.svh"
module tb;
  logic pclk, presetn, psel, penable, pwrite, rx_run, perr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, counter_latch, cez, irq, rx_clk;
  logic [17:0] lv;
  int err_total, check_count, latch_n, n0;

  // lv: 1 link, 2 slot bit, 3-5 search, 6 expiry, 7 mf, 8 second, 9 global_counter_latch, 17:10 sig
  e1rxs_line_model line (.pclk(pclk), .rx_run(rx_run), .rx_clk(rx_clk), .lv(lv));
  e1rxs_status #(.SEC_E1_BITS(21'd40), .SEC_T1_BITS(21'd30), .SHORT_E1_BITS(21'd20),
    .SHORT_T1_BITS(21'd16)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_clk(rx_clk), .link_id_seen(lv[1]),
    .ts16_f0_bit6(lv[2]), .crc_mf_search_active(lv[3]), .signaling_mf_search_active(lv[4]),
    .frame_align_search_active(lv[5]), .crc_search_expired_tgl(lv[6]),
    .cas_mf_boundary_tgl(lv[7]), .shared_second_tgl(lv[8]), .global_counter_latch(lv[9]),
    .sig_change_tgl(lv[17:10]), .counter_latch(counter_latch), .count_excess_zeros(cez),
    .irq(irq));

  // Clock, 100 MHz
  always #5 pclk = ~pclk;

  // Count latch pulses
  always @(posedge pclk) if (counter_latch === 1'b1) latch_n++;

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t %s got %h expected %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc

  // One APB transfer; waits for pready, bounded
  task automatic apb(input logic w, input logic [9:0] i, input logic [7:0] d,
      output logic [7:0] r);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= {d, d, d, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) err_total++;
    r = prdata[7:0];
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [9:0] i, input logic [7:0] d);
    logic [7:0] r;
    apb(1'b1, i, d, r);
  endtask : wr

  task automatic rdc(input logic [9:0] i, input logic [7:0] e, input logic [7:0] m,
      input string s);
    logic [7:0] r;
    apb(1'b0, i, 8'h00, r);
    chk(r & m, e, s);
  endtask : rdc

  task automatic t_reset;
    logic [9:0] ix [8];
    ix = '{`E1RXS_IDX_RTS7, `E1RXS_IDX_ERROR_COUNTER_CONFIG, `E1RXS_IDX_RX_LATCHED_ALARM_STATUS_C, `E1RXS_IDX_RX_LATCHED_EVENT_STATUS_D,
      `E1RXS_IDX_RX_IRQ_MASK_C, `E1RXS_IDX_RX_IRQ_MASK_D, `E1RXS_IDX_SCE1, `E1RXS_IDX_CTRL};
    for (int k = 0; k < 8; k++) begin
      rdc(ix[k], 8'h00, 8'hff, "reset value");
    end
    rdc(10'h001, 8'h00, 8'hff, "unmapped read");
    chk({7'h0, perr}, 8'h01, "unmapped error");
  endtask : t_reset

  task automatic t_masks;
    wr(`E1RXS_IDX_RX_IRQ_MASK_C, 8'hbb);
    rdc(`E1RXS_IDX_RX_IRQ_MASK_C, 8'hbb, 8'hff, "mask c");
    wr(`E1RXS_IDX_RX_IRQ_MASK_D, 8'h0f);
    rdc(`E1RXS_IDX_RX_IRQ_MASK_D, 8'h0f, 8'hff, "mask d");
    wr(`E1RXS_IDX_ERROR_COUNTER_CONFIG, 8'hf9);
    rdc(`E1RXS_IDX_ERROR_COUNTER_CONFIG, 8'hf9, 8'hff, "config");
    chk({7'h0, cez}, 8'h01, "excess zeros on");
    wr(`E1RXS_IDX_ERROR_COUNTER_CONFIG, 8'h00);
    cyc(2);
    chk({7'h0, cez}, 8'h00, "excess zeros off");
    wr(`E1RXS_IDX_RX_IRQ_MASK_C, 8'h00);
    wr(`E1RXS_IDX_RX_IRQ_MASK_D, 8'h00);
  endtask : t_masks

  task automatic t_clock;
    wr(`E1RXS_IDX_RX_LATCHED_ALARM_STATUS_C, 8'hff);
    rx_run <= 1'b0;
    cyc(370);
    rdc(`E1RXS_IDX_RX_LATCHED_ALARM_STATUS_C, 8'h00, 8'hff, "clock lost early");
    cyc(45);
    rdc(`E1RXS_IDX_RX_LATCHED_ALARM_STATUS_C, 8'h08, 8'hff, "clock lost");
    rx_run <= 1'b1;
    cyc(20);
    rdc(`E1RXS_IDX_RX_LATCHED_ALARM_STATUS_C, 8'h88, 8'hff, "clock back");
    wr(`E1RXS_IDX_RX_LATCHED_ALARM_STATUS_C, 8'hff);
  endtask : t_clock

  task automatic t_link;
    wr(`E1RXS_IDX_RX_IRQ_MASK_C, 8'h02);
    line.put(1, 1'b1);
    rdc(`E1RXS_IDX_RX_LATCHED_ALARM_STATUS_C, 8'h02, 8'hff, "link up");
    chk({7'h0, irq}, 8'h01, "irq passed");
    line.put(1, 1'b0);
    rdc(`E1RXS_IDX_RX_LATCHED_ALARM_STATUS_C, 8'h22, 8'hff, "link down");
    wr(`E1RXS_IDX_RX_LATCHED_ALARM_STATUS_C, 8'h02);
    rdc(`E1RXS_IDX_RX_LATCHED_ALARM_STATUS_C, 8'h20, 8'hff, "one clear");
    chk({7'h0, irq}, 8'h00, "irq blocked");
    wr(`E1RXS_IDX_RX_LATCHED_ALARM_STATUS_C, 8'hff);
  endtask : t_link

  task automatic t_dma;
    wr(`E1RXS_IDX_CTRL, 8'h04);
    wr(`E1RXS_IDX_RX_LATCHED_EVENT_STATUS_D, 8'hff);
    line.put(2, 1'b1);
    rdc(`E1RXS_IDX_RX_LATCHED_EVENT_STATUS_D, 8'h00, 8'h01, "no boundary");
    line.flip(7);
    rdc(`E1RXS_IDX_RX_LATCHED_ALARM_STATUS_C, 8'h00, 8'h11, "one mf");
    rdc(`E1RXS_IDX_RX_LATCHED_EVENT_STATUS_D, 8'h01, 8'h01, "mf event");
    line.flip(7);
    rdc(`E1RXS_IDX_RX_LATCHED_ALARM_STATUS_C, 8'h01, 8'h11, "alarm on");
    line.put(2, 1'b0);
    line.flip(7);
    rdc(`E1RXS_IDX_RX_LATCHED_ALARM_STATUS_C, 8'h11, 8'h11, "alarm off");
  endtask : t_dma

  task automatic t_sync;
    wr(`E1RXS_IDX_CTRL, 8'h05);
    line.put(3, 1'b1);
    line.put(5, 1'b1);
    repeat (3) line.flip(6);
    rdc(`E1RXS_IDX_RTS7, 8'h0d, 8'hff, "count 3");
    repeat (63) line.flip(6);
    rdc(`E1RXS_IDX_RTS7, 8'h05, 8'hff, "rolled to 2");
    line.flip(6);
    rdc(`E1RXS_IDX_RTS7, 8'h0d, 8'hff, "count 3 again");
    line.put(3, 1'b0);
    rdc(`E1RXS_IDX_RTS7, 8'h01, 8'hff, "sync clear");
    line.put(3, 1'b1);
    line.flip(6);
    line.put(4, 1'b1);
    rdc(`E1RXS_IDX_RTS7, 8'h0f, 8'hff, "search bits");
    wr(`E1RXS_IDX_CTRL, 8'h04);
    rdc(`E1RXS_IDX_RTS7, 8'h07, 8'hff, "disable clear");
  endtask : t_sync

  task automatic t_sig;
    wr(`E1RXS_IDX_SCE1, 8'h04);
    wr(`E1RXS_IDX_RX_LATCHED_EVENT_STATUS_D, 8'hff);
    line.flip(10);
    line.flip(11);
    for (int k = 13; k < 18; k++) begin
      line.flip(k);
    end
    rdc(`E1RXS_IDX_RX_LATCHED_EVENT_STATUS_D, 8'h00, 8'h08, "channel off");
    line.flip(12);
    rdc(`E1RXS_IDX_RX_LATCHED_EVENT_STATUS_D, 8'h08, 8'h08, "channel on");
  endtask : t_sig

  task automatic t_timer;
    wr(`E1RXS_IDX_ERROR_COUNTER_CONFIG, 8'h10);
    wr(`E1RXS_IDX_RX_LATCHED_EVENT_STATUS_D, 8'hff);
    cyc(400);
    rdc(`E1RXS_IDX_RX_LATCHED_EVENT_STATUS_D, 8'h02, 8'h02, "short timer");
    cyc(700);
    rdc(`E1RXS_IDX_RX_LATCHED_EVENT_STATUS_D, 8'h04, 8'h04, "one second");
  endtask : t_timer

  task automatic t_latch;
    wr(`E1RXS_IDX_ERROR_COUNTER_CONFIG, 8'h08);
    n0 = latch_n;
    wr(`E1RXS_IDX_ERROR_COUNTER_CONFIG, 8'h28);
    cyc(2);
    chk(8'(latch_n - n0), 8'h01, "manual latch");
    n0 = latch_n;
    cyc(1200);
    chk(8'(latch_n - n0), 8'h00, "manual quiet");
    wr(`E1RXS_IDX_ERROR_COUNTER_CONFIG, 8'h48);
    n0 = latch_n;
    line.put(9, 1'b1);
    line.put(9, 1'b0);
    chk(8'(latch_n - n0), 8'h01, "global latch");
    wr(`E1RXS_IDX_ERROR_COUNTER_CONFIG, 8'h80);
    n0 = latch_n;
    line.flip(8);
    line.flip(8);
    chk(8'(latch_n - n0), 8'h02, "shared second");
    wr(`E1RXS_IDX_ERROR_COUNTER_CONFIG, 8'h10);
    n0 = latch_n;
    cyc(1200);
    chk({7'h0, (latch_n - n0) >= 3}, 8'h01, "short updates");
    // T1 short interval, 16 line edges here
    wr(`E1RXS_IDX_CTRL, 8'h02);
    n0 = latch_n;
    cyc(2600);
    chk({7'h0, (latch_n - n0) >= 10 && (latch_n - n0) <= 11}, 8'h01, "t1 updates");
    wr(`E1RXS_IDX_CTRL, 8'h00);
    wr(`E1RXS_IDX_ERROR_COUNTER_CONFIG, 8'h00);
    n0 = latch_n;
    cyc(1200);
    chk({7'h0, (latch_n - n0) <= 2}, 8'h01, "second updates");
  endtask : t_latch

  task automatic stop_test;
    $display("Mismatches %0d, checks %0d", err_total, check_count);
    if (err_total == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : stop_test

  // Main sequence, reset held for three edges
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    rx_run = 1'b1;
    err_total = 0;
    check_count = 0;
    latch_n = 0;
    cyc(3);
    presetn <= 1'b1;
    cyc(1);
    t_reset;
    t_masks;
    t_clock;
    t_link;
    t_dma;
    t_sync;
    t_sig;
    t_timer;
    t_latch;
    stop_test;
  end

  // Watchdog, well past the expected run length
  initial begin
    #500000;
    err_total++;
    stop_test;
  end
endmodule : tb
